//--- hw/sgp_pkg.sv
// Constants and register map of the shared eight-pin port
// Operation
// - Direction 1 drives pin, 0 makes input
// - Output pin driven from data latch
// - Writes with pstrb[0] set update latch, driven only outputs
// - Output pins read back latch value
// - Input pins read pin; RMW reads latch
// - Peripheral output enable overrides latch drive
// - Peripheral driven pin reads pin level
// - Analog disable 0 analog, 1 digital input
// - Reset clears all direction bits
// - Reset clears analog input disable bits
// - Standby isolate: pins Hi-Z, input forced low
// - Enabled interrupt pins keep input during isolate
// - Isolate bit 0 keeps pin states
// - Pin level feeds interrupt circuit, except non-enabled pins during isolate
// - Normal read returns pin regardless peripheral input
// - Data and direction reset zero; RMW reads latch
package sgp_pkg;
    // *****************************************************
    // Register byte addresses
    // *****************************************************
    localparam logic [11:0] ADDR_PORT_OUTPUT_LATCH  = 12'h000;
    localparam logic [11:0] ADDR_PORT_DIRECTION     = 12'h004;
    localparam logic [11:0] ADDR_ANALOG_DISABLE_LOW = 12'h008;
    localparam logic [11:0] ADDR_PORT_CONTROL       = 12'h00c;
    localparam logic [11:0] ADDR_PIN_STATUS         = 12'h010;
    localparam logic [11:0] ADDR_LATCH_RMW_VIEW     = 12'h014;
    // *****************************************************
    // Reset values and field positions
    // *****************************************************
    localparam logic [7:0] RESET_PORT_OUTPUT_LATCH  = 8'h00;
    localparam logic [7:0] RESET_PORT_DIRECTION     = 8'h00;
    localparam logic [7:0] RESET_ANALOG_DISABLE     = 8'h00;
    localparam int         CTRL_RMW_READ_BIT        = 0;
    localparam int         CTRL_PIN_ISOLATE_BIT     = 1;
    localparam int         STAT_STANDBY_BIT         = 0;
    localparam int         STAT_ISOLATED_BIT        = 1;
endpackage : sgp_pkg

//--- hw/sgp_pin_cell.sv
// One port pin: drive selection and isolated input path
`timescale 1ns/1ps
`default_nettype none
module sgp_pin_cell (
    input  wire logic latch_bit,
    input  wire logic dir_bit,
    input  wire logic periph_oe,
    input  wire logic periph_out,
    input  wire logic analog_dis,
    input  wire logic isolate,
    input  wire logic irq_enable,
    input  wire logic pin_in,
    output var  logic drive_val,
    output var  logic drive_en,
    output var  logic digital_in,
    output var  logic irq_in
);
    logic block_input;
    always_comb begin
        block_input = isolate && !irq_enable;
        drive_en    = !isolate && (periph_oe || dir_bit);
        drive_val   = periph_oe ? periph_out : latch_bit;
        digital_in  = (analog_dis && !block_input) ? pin_in : 1'b0;
        irq_in      = block_input ? 1'b0 : pin_in;
    end
endmodule : sgp_pin_cell
`default_nettype wire

//--- hw/sgp_readback.sv
// Read data selection for the port data register
`timescale 1ns/1ps
`default_nettype none
module sgp_readback #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] latch,
    input  wire logic [WIDTH-1:0] dir,
    input  wire logic [WIDTH-1:0] periph_oe,
    input  wire logic [WIDTH-1:0] pin_level,
    input  wire logic             rmw,
    output var  logic [WIDTH-1:0] data
);
    always_comb begin
        if (rmw) begin
            data = latch;
        end else begin
            data = (dir & ~periph_oe & latch) | (~(dir & ~periph_oe) & pin_level);
        end
    end
endmodule : sgp_readback
`default_nettype wire

//--- hw/sgp_port.sv
// Shared eight-pin general-purpose port with APB registers
`timescale 1ns/1ps
`default_nettype none
module sgp_port #(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe,
    input  wire logic [WIDTH-1:0] periph_oe,
    input  wire logic [WIDTH-1:0] periph_out,
    input  wire logic [WIDTH-1:0] irq_enable,
    input  wire logic             standby_enter,
    output logic      [WIDTH-1:0] digital_in,
    output logic      [WIDTH-1:0] irq_in,
    output logic      [WIDTH-1:0] analog_sel
);
    // *****************************************************
    // Registers
    // *****************************************************
    logic [WIDTH-1:0] port_output_latch;
    logic [WIDTH-1:0] port_direction;
    logic [WIDTH-1:0] analog_input_disable_low;
    logic             rmw_read;
    logic             standby_pin_isolate;
    logic             isolated;
    logic [WIDTH-1:0] next_pin_out;
    logic [WIDTH-1:0] next_pin_oe;
    logic [WIDTH-1:0] next_digital_in;
    logic [WIDTH-1:0] next_irq_in;
    logic [WIDTH-1:0] read_view;
    logic [31:0]      next_prdata;
    logic             setup;
    logic             wr_access;
    logic             mapped;

    localparam logic [11:0] ADDR_PORT_OUTPUT_LATCH_L = sgp_pkg::ADDR_PORT_OUTPUT_LATCH;
    localparam logic [11:0] ADDR_PORT_DIRECTION_L    = sgp_pkg::ADDR_PORT_DIRECTION;
    localparam logic [11:0] ADDR_ANALOG_DISABLE_L    = sgp_pkg::ADDR_ANALOG_DISABLE_LOW;
    localparam logic [11:0] ADDR_PORT_CONTROL_L      = sgp_pkg::ADDR_PORT_CONTROL;
    localparam logic [11:0] ADDR_PIN_STATUS_L        = sgp_pkg::ADDR_PIN_STATUS;
    localparam logic [11:0] ADDR_LATCH_RMW_VIEW_L    = sgp_pkg::ADDR_LATCH_RMW_VIEW;

    assign setup     = psel && !penable;
    assign wr_access = psel && penable && pwrite && pready && pstrb[0];

    always_comb begin
        unique case (paddr)
            ADDR_PORT_OUTPUT_LATCH_L, ADDR_PORT_DIRECTION_L, ADDR_ANALOG_DISABLE_L,
            ADDR_PORT_CONTROL_L, ADDR_PIN_STATUS_L, ADDR_LATCH_RMW_VIEW_L: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // *****************************************************
    // APB handshake: no wait state, answer in first access cycle
    // *****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_output_latch <= sgp_pkg::RESET_PORT_OUTPUT_LATCH;
        end else if (wr_access && paddr == ADDR_PORT_OUTPUT_LATCH_L) begin
            port_output_latch <= pwdata[WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_direction <= sgp_pkg::RESET_PORT_DIRECTION;
        end else if (wr_access && paddr == ADDR_PORT_DIRECTION_L) begin
            port_direction <= pwdata[WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_input_disable_low <= sgp_pkg::RESET_ANALOG_DISABLE;
        end else if (wr_access && paddr == ADDR_ANALOG_DISABLE_L) begin
            analog_input_disable_low <= pwdata[WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rmw_read            <= 1'b0;
            standby_pin_isolate <= 1'b0;
        end else if (wr_access && paddr == ADDR_PORT_CONTROL_L) begin
            rmw_read            <= pwdata[sgp_pkg::CTRL_RMW_READ_BIT];
            standby_pin_isolate <= pwdata[sgp_pkg::CTRL_PIN_ISOLATE_BIT];
        end
    end

    // *****************************************************
    // Standby isolation state
    // *****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            isolated <= 1'b0;
        end else begin
            isolated <= standby_enter && standby_pin_isolate;
        end
    end

    // *****************************************************
    // Pin cells
    // *****************************************************
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        sgp_pin_cell u_cell (
            .latch_bit  (port_output_latch[i]),
            .dir_bit    (port_direction[i]),
            .periph_oe  (periph_oe[i]),
            .periph_out (periph_out[i]),
            .analog_dis (analog_input_disable_low[i]),
            .isolate    (isolated),
            .irq_enable (irq_enable[i]),
            .pin_in     (pin_in[i]),
            .drive_val  (next_pin_out[i]),
            .drive_en   (next_pin_oe[i]),
            .digital_in (next_digital_in[i]),
            .irq_in     (next_irq_in[i])
        );
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out    <= '0;
            pin_oe     <= '0;
            digital_in <= '0;
            irq_in     <= '0;
            analog_sel <= '0;
        end else begin
            pin_out    <= next_pin_out;
            pin_oe     <= next_pin_oe;
            digital_in <= next_digital_in;
            irq_in     <= next_irq_in;
            analog_sel <= ~analog_input_disable_low & ~port_direction;
        end
    end

    // *****************************************************
    // Read path
    // *****************************************************
    sgp_readback #(.WIDTH(WIDTH)) u_readback (
        .latch     (port_output_latch),
        .dir       (port_direction),
        .periph_oe (periph_oe),
        .pin_level (pin_in),
        .rmw       (rmw_read || paddr == ADDR_LATCH_RMW_VIEW_L),
        .data      (read_view)
    );

    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            ADDR_PORT_OUTPUT_LATCH_L, ADDR_LATCH_RMW_VIEW_L: next_prdata[WIDTH-1:0] = read_view;
            ADDR_PORT_DIRECTION_L: next_prdata[WIDTH-1:0] = port_direction;
            ADDR_ANALOG_DISABLE_L: next_prdata[WIDTH-1:0] = analog_input_disable_low;
            ADDR_PORT_CONTROL_L: begin
                next_prdata[sgp_pkg::CTRL_RMW_READ_BIT]    = rmw_read;
                next_prdata[sgp_pkg::CTRL_PIN_ISOLATE_BIT] = standby_pin_isolate;
            end
            ADDR_PIN_STATUS_L: begin
                next_prdata[sgp_pkg::STAT_STANDBY_BIT]  = standby_enter;
                next_prdata[sgp_pkg::STAT_ISOLATED_BIT] = isolated;
            end
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= next_prdata;
        end
    end
endmodule : sgp_port
`default_nettype wire

//--- dv/sgp_pin_model.sv
// Pin-side model: external levels and resolved pin state
`timescale 1ns/1ps
`default_nettype none
module sgp_pin_model (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] ext_level,
    output logic      [7:0] pin_in
);
    // Driven pins show the port, released ones the outside driver
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : sgp_pin_model
`default_nettype wire

//--- dv/sgp_port_sva.sv
// Assertion checker for the shared port
`timescale 1ns/1ps
`default_nettype none
module sgp_port_sva #(
    parameter int WIDTH = 8
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [3:0]       pstrb,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic [WIDTH-1:0] pin_out,
    input wire logic [WIDTH-1:0] pin_oe,
    input wire logic [WIDTH-1:0] periph_oe,
    input wire logic [WIDTH-1:0] periph_out,
    input wire logic [WIDTH-1:0] irq_enable,
    input wire logic             standby_enter,
    input wire logic [WIDTH-1:0] digital_in,
    input wire logic [WIDTH-1:0] irq_in,
    input wire logic [WIDTH-1:0] analog_sel
);
    logic ctl_iso;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow of the isolate control bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ctl_iso <= 1'b0;
        else if (psel && penable && pready && pwrite && pstrb[0]
                 && paddr == sgp_pkg::ADDR_PORT_CONTROL)
            ctl_iso <= pwdata[sgp_pkg::CTRL_PIN_ISOLATE_BIT];
    end
    a_ready_setup: assert property (psel && !penable |=> pready && !$past(pready))
        else $error("ready missing after setup");
    a_ready_single: assert property (pready |=> !pready) else $error("ready too long");
    a_unmapped_err: assert property (psel && !penable && paddr >= 12'h018
        |=> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped not refused");
    a_periph_drive: assert property (
        (!standby_enter && $stable(periph_oe) && $stable(periph_out))[*3]
        |-> (pin_oe & periph_oe) == periph_oe && ((pin_out ^ periph_out) & periph_oe) == '0)
        else $error("peripheral not driving");
    a_isolate_hiz: assert property (
        (standby_enter && ctl_iso && $stable(irq_enable))[*3] |-> pin_oe == '0
        && (digital_in & ~irq_enable) == '0 && (irq_in & ~irq_enable) == '0)
        else $error("isolation incomplete");
    a_isolate_irq: assert property (
        (standby_enter && ctl_iso && $stable(irq_enable) && $stable(pin_in))[*4]
        |-> (irq_in & irq_enable) == (pin_in & irq_enable)) else $error("irq blocked");
    a_hold_state: assert property (
        (standby_enter && !ctl_iso && !psel && $stable(periph_oe) && $stable(periph_out))[*3]
        |-> $stable(pin_oe) && $stable(pin_out)) else $error("pins changed in standby");
    a_irq_follow: assert property (
        (!(standby_enter && ctl_iso) && $stable(pin_in))[*4] |-> irq_in == pin_in)
        else $error("irq input not pin level");
    a_analog_excl: assert property ((analog_sel & digital_in) == '0)
        else $error("analog pin feeds digital input");
    a_reset_state: assert property ($rose(presetn) |-> ##[0:2]
        (analog_sel == '1 && pin_oe == '0 && digital_in == '0)) else $error("bad reset state");
endmodule : sgp_port_sva
bind sgp_port sgp_port_sva #(.WIDTH(WIDTH)) sva_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .periph_oe(periph_oe), .periph_out(periph_out),
    .irq_enable(irq_enable), .standby_enter(standby_enter), .digital_in(digital_in),
    .irq_in(irq_in), .analog_sel(analog_sel));
`default_nettype wire

//--- dv/shared_gpio_port_zero_tb_top.sv
// Self-checking bench for the shared port
`timescale 1ns/1ps
`default_nettype none
module shared_gpio_port_zero_tb_top;
    localparam logic [11:0] A_LAT = sgp_pkg::ADDR_PORT_OUTPUT_LATCH;
    localparam logic [11:0] A_DIR = sgp_pkg::ADDR_PORT_DIRECTION;
    localparam logic [11:0] A_DIS = sgp_pkg::ADDR_ANALOG_DISABLE_LOW;
    localparam logic [11:0] A_CTL = sgp_pkg::ADDR_PORT_CONTROL;
    localparam logic [11:0] A_STS = sgp_pkg::ADDR_PIN_STATUS;
    localparam logic [11:0] A_RMW = sgp_pkg::ADDR_LATCH_RMW_VIEW;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, standby_enter = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, err;
    logic [7:0]  pin_in, pin_out, pin_oe, digital_in, irq_in, analog_sel;
    logic [7:0]  periph_oe = '0, periph_out = '0, irq_enable = '0, ext_level = 8'h96;
    int          bad_count = 0, n_compared = 0;
    always #5 pclk = ~pclk;
    sgp_port #(.WIDTH(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .periph_oe(periph_oe), .periph_out(periph_out),
        .irq_enable(irq_enable), .standby_enter(standby_enter), .digital_in(digital_in),
        .irq_in(irq_in), .analog_sel(analog_sel));
    sgp_pin_model model_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .pin_in(pin_in));
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // One APB transfer, held until ready is sampled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            report_and_stop;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rchk
    // Lets register and pin changes reach the outputs
    task automatic settle;
        repeat (4) @(posedge pclk);
    endtask : settle
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(A_DIR, 32'h0);
        rchk(A_DIS, 32'h0);
        rchk(A_RMW, 32'h0);
        check(analog_sel, 8'hff);
        $display("test reset done");
        wr(A_DIR, 32'hff);
        wr(A_LAT, 32'ha5);
        settle;
        check(pin_oe, 8'hff);
        check(pin_out, 8'ha5);
        rchk(A_LAT, 32'ha5);
        $display("test output done");
        wr(A_DIR, 32'h0f);
        wr(A_LAT, 32'h3c);
        wr(A_DIS, 32'hff);
        settle;
        check(pin_oe, 8'h0f);
        check(pin_out & pin_oe, 8'h0c);
        rchk(A_LAT, 32'h9c);
        rchk(A_RMW, 32'h3c);
        wr(A_CTL, 32'h1);
        rchk(A_LAT, 32'h3c);
        wr(A_CTL, 32'h0);
        check(digital_in, 8'h9c);
        check(irq_in, 8'h9c);
        $display("test input done");
        periph_oe <= 8'h81;
        periph_out <= 8'h01;
        settle;
        check(pin_oe, 8'h8f);
        check(pin_out & pin_oe, 8'h0d);
        rchk(A_LAT, 32'h1d);
        rchk(A_RMW, 32'h3c);
        pstrb <= 4'h0;
        wr(A_LAT, 32'hff);
        pstrb <= 4'hf;
        rchk(A_RMW, 32'h3c);
        periph_oe <= 8'h00;
        wr(A_DIS, 32'h0);
        settle;
        check(analog_sel, 8'hf0);
        check(digital_in, 8'h00);
        wr(A_DIS, 32'hff);
        $display("test shared done");
        irq_enable <= 8'h80;
        wr(A_CTL, 32'h2);
        standby_enter <= 1'b1;
        settle;
        check(pin_oe, 8'h00);
        check(irq_in, 8'h80);
        check(digital_in, 8'h80);
        rchk(A_STS, 32'h3);
        rchk(A_CTL, 32'h2);
        standby_enter <= 1'b0;
        wr(A_CTL, 32'h0);
        standby_enter <= 1'b1;
        settle;
        check(pin_oe, 8'h0f);
        check(pin_out & pin_oe, 8'h0c);
        rchk(A_STS, 32'h1);
        standby_enter <= 1'b0;
        apb(1'b0, 12'h020, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        $display("test standby done");
        report_and_stop;
    end
endmodule : shared_gpio_port_zero_tb_top
`default_nettype wire
